// ==== pmd_top.sv ====
// processing module address decode, exception and interrupt logic
// How it works
// RL1 - user privilege accepts only user memory, else bus error
// RL2 - system bus faults become bus error exceptions
// RL3 - user space is 2 GB, paged in 4 kB pages
// RL4 - supervisor space holds user space, 1 GB kernel, 1 GB I/O
// RL5 - supervisor access to user space uses user root pointer
// RL6 - off-board I/O mapped to bus addresses per 1 MB section
// RL7 - local I/O and test decodes are fixed and supervisor only
// RL8 - hits and writes no wait, after write hit one, miss six
// RL9 - read-modify-write cycles stay atomic with the arbiter
// RL10 - foreign plain writes are not held off by a locked cycle
// RL11 - reset instruction delays 64 to 150 us, interrupts ignored
// RL12 - breakpoint becomes illegal-instruction, four-word frame
// RL13 - missing float unit or bad encoding gives vector 11
// RL14 - any other coprocessor id gives the coprocessor-line trap
// RL15 - boot rom mirrors all supervisor space until local write
// RL16 - diagnostic and command requests are level 7, diag unmasked
// RL17 - seven one-bit request registers loadable from the bus
// RL18 - acknowledge by autovector, acknowledge leaves request set
// RL19 - writing the ack-done address re-arms command intake
// RL20 - command write with no free buffer waits, may time out
// RL21 - current priority level readable by other modules
// RL22 - priority level readable at top control offset
// RL23 - priority is highest pending level, every clock
// RL24 - free count drops per accepted command, never above max
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pmd_regs.svh"
module pmd_top
  import pmd_pkg::*;
#(
  parameter int RST_CYCLES = `PMD_RST_CYCLES,
  parameter int MISS_WAIT = `PMD_MISS_WAIT,
  parameter int CMD_BUFS = `PMD_CMD_BUFS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // processor access
  input wire logic cpu_as,
  input wire logic cpu_super,
  input wire logic cpu_write,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_rmw,
  input wire logic cpu_hit,
  input wire logic bus_fault,
  output logic bus_err,
  output logic [1:0] cpu_space,
  output logic rom_sel,
  output logic user_root_sel,
  output logic [19:0] page_num,
  output logic [31:0] io_phys,
  output logic [2:0] wait_cnt,
  // arbiter lock
  output logic arb_modify,
  input wire logic arb_lock_grant,
  input wire logic foreign_write,
  output logic foreign_overwritten,
  // instruction decode
  input wire logic reset_instr,
  input wire logic breakpoint_instr,
  input wire logic cop_instr,
  input wire logic [2:0] cop_id,
  input wire logic cop_bad_encoding,
  output logic exc_req,
  output logic [7:0] exc_vector,
  output logic [1:0] exc_frame_words_m4,
  output logic reset_busy,
  // interrupts
  input wire logic diag_irq,
  input wire logic cmd_write,
  output logic cmd_wait,
  input wire logic iack,
  output logic [7:0] iack_vector,
  output logic [2:0] interrupt_priority_inputs
);
  localparam logic [31:0] ROM_MASK = `PMD_ROM_BYTES - 32'h1;
  logic diag_s1_q, diag_s_q;
  logic [31:0] ctrl_q;
  logic [6:0] irq_q;
  logic [7:0] iomap_idx_q;
  logic [11:0] iomap_q [0:255];
  logic [3:0] free_q;
  logic [31:0] rst_cnt_q;
  logic cmd_pend_q;
  logic [2:0] lvl_d;
  logic after_wh_q;
  pmd_rmw_t rmw_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic wr_fire, ack_done;

  always_ff @(posedge aclk) begin
    diag_s1_q <= diag_irq;
    diag_s_q <= diag_s1_q;
  end

  function automatic pmd_space_t space_of(input logic [31:0] a);
    if (!a[31]) begin
      space_of = PMD_SP_USER;
    end else if (!a[30]) begin
      space_of = PMD_SP_KERNEL;
    end else if (a[31:24] == 8'hff) begin
      space_of = PMD_SP_LOCAL;
    end else begin
      space_of = PMD_SP_IO;
    end
  endfunction

  // address decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_err <= 1'b0;
      cpu_space <= 2'h0;
      rom_sel <= 1'b0;
      user_root_sel <= 1'b0;
      page_num <= 20'h0;
      io_phys <= 32'h0;
    end else begin
      cpu_space <= space_of(cpu_addr); // RL4
      page_num <= {1'b0, cpu_addr[30:`PMD_PAGE_BITS]}; // RL3
      user_root_sel <= space_of(cpu_addr) == PMD_SP_USER; // RL5
      io_phys <= {iomap_q[cpu_addr[27:20]],
                  cpu_addr[`PMD_SECTION_BITS-1:0]}; // RL6
      rom_sel <= cpu_as && cpu_super &&
                 (!ctrl_q[`PMD_CTRL_ROM_NORMAL] ||
                  (space_of(cpu_addr) == PMD_SP_LOCAL &&
                   (cpu_addr & ~ROM_MASK) == 32'hff00_0000)); // RL15
      bus_err <= cpu_as && (bus_fault || // RL2
                 (!cpu_super && space_of(cpu_addr) != PMD_SP_USER)); // RL1 RL7
    end
  end

  // wait states
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt <= 3'h0;
      after_wh_q <= 1'b0;
    end else if (cpu_as) begin
      after_wh_q <= cpu_write && cpu_hit;
      if (cpu_write || (cpu_hit && !after_wh_q)) begin
        wait_cnt <= 3'h0; // RL8
      end else if (cpu_hit) begin
        wait_cnt <= 3'h1; // RL8
      end else begin
        wait_cnt <= MISS_WAIT[2:0]; // RL8
      end
    end else begin
      wait_cnt <= 3'h0;
    end
  end

  // locked read-modify-write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rmw_q <= PMD_RMW_IDLE;
      arb_modify <= 1'b0;
      foreign_overwritten <= 1'b0;
    end else begin
      foreign_overwritten <= 1'b0;
      unique case (rmw_q)
        PMD_RMW_IDLE: if (cpu_as && cpu_rmw) begin
          rmw_q <= PMD_RMW_WAIT;
          arb_modify <= 1'b1; // RL9
        end
        PMD_RMW_WAIT: if (arb_lock_grant) begin
          rmw_q <= PMD_RMW_LOCK;
        end
        PMD_RMW_LOCK: begin
          if (foreign_write) begin
            foreign_overwritten <= 1'b1; // RL10
          end
          if (cpu_as && cpu_write) begin
            rmw_q <= PMD_RMW_IDLE;
            arb_modify <= 1'b0; // RL9
          end
        end
        default: rmw_q <= PMD_RMW_IDLE;
      endcase
    end
  end

  // reset instruction delay and exceptions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_q <= 32'h0;
      reset_busy <= 1'b0;
    end else if (reset_instr && !reset_busy) begin
      rst_cnt_q <= RST_CYCLES;
      reset_busy <= 1'b1; // RL11
    end else if (rst_cnt_q > 32'h1) begin
      rst_cnt_q <= rst_cnt_q - 32'h1;
    end else begin
      rst_cnt_q <= 32'h0;
      reset_busy <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exc_req <= 1'b0;
      exc_vector <= 8'h0;
      exc_frame_words_m4 <= 2'h0;
    end else begin
      exc_req <= 1'b0;
      exc_frame_words_m4 <= 2'h0; // RL12
      if (breakpoint_instr) begin
        exc_req <= 1'b1;
        exc_vector <= `PMD_VEC_ILLEGAL; // RL12
      end else if (cop_instr && (cop_id != `PMD_FPU_CPID || // RL14
                   !ctrl_q[`PMD_CTRL_FPU_PRESENT] || cop_bad_encoding)) begin
        exc_req <= 1'b1;
        exc_vector <= `PMD_VEC_FLINE; // RL13
      end
    end
  end

  // interrupt level and acknowledge
  always_comb begin
    lvl_d = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (irq_q[i]) begin
        lvl_d = 3'(i + 1); // RL23
      end
    end
    if (diag_s_q || cmd_pend_q) begin
      lvl_d = 3'h7; // RL16
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_priority_inputs <= 3'h0;
      iack_vector <= 8'h0;
    end else begin
      interrupt_priority_inputs <= reset_busy ? 3'h0 : lvl_d; // RL11 RL23
      if (iack) begin
        iack_vector <= `PMD_VEC_AUTO_BASE +
                       {5'h0, interrupt_priority_inputs}; // RL18
      end
    end
  end

  // command buffers
  assign ack_done = wr_fire && aw_q == `PMD_OFF_ACK_DONE;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_q <= 4'(CMD_BUFS);
      cmd_pend_q <= 1'b0;
      cmd_wait <= 1'b0;
    end else begin
      cmd_wait <= cmd_write && free_q == 4'h0; // RL20
      if (cmd_write && free_q != 4'h0) begin
        cmd_pend_q <= 1'b1;
        free_q <= ack_done ? free_q : free_q - 4'h1; // RL24
      end else if (ack_done && free_q < 4'(CMD_BUFS)) begin
        free_q <= free_q + 4'h1; // RL19
        cmd_pend_q <= 1'b0;
      end
    end
  end

  // axi4-lite write
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_q <= 8'h0;
      wd_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `PMD_CTRL_RESET;
      irq_q <= 7'h0;
      iomap_idx_q <= 8'h0;
    end else if (wr_fire) begin
      unique case (aw_q)
        `PMD_OFF_CTRL: ctrl_q <= {30'h0, wd_q[1:0]}; // RL15
        `PMD_OFF_IRQ: irq_q <= wd_q[6:0]; // RL17
        `PMD_OFF_IOMAP_IDX: iomap_idx_q <= wd_q[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_fire && aw_q == `PMD_OFF_IOMAP_DATA) begin
      iomap_q[iomap_idx_q] <= wd_q[11:0]; // RL6
    end
  end

  // axi4-lite read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          `PMD_OFF_CTRL: s_axi_rdata <= ctrl_q;
          `PMD_OFF_STATUS: s_axi_rdata <= {24'h0, rmw_q, reset_busy,
                                           cmd_pend_q, free_q}; // RL21
          `PMD_OFF_IRQ: s_axi_rdata <= {25'h0, irq_q};
          `PMD_OFF_FREEBUF: s_axi_rdata <= {28'h0, free_q};
          `PMD_OFF_IOMAP_IDX: s_axi_rdata <= {24'h0, iomap_idx_q};
          `PMD_OFF_IOMAP_DATA: s_axi_rdata <= {20'h0,
                                               iomap_q[iomap_idx_q]};
          `PMD_OFF_LEVEL: s_axi_rdata <= {29'h0,
                                          interrupt_priority_inputs}; // RL22
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  user_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_as && !cpu_super && cpu_addr[31] |=> bus_err)
    else $error("user non-user decode without bus error"); // RL1
  fault_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_as && bus_fault |=> bus_err)
    else $error("bus fault not reported"); // RL2
  miss_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_as && !cpu_write && !cpu_hit |=> wait_cnt == 3'h6)
    else $error("miss wait count wrong"); // RL8
  rst_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    reset_busy ##1 reset_busy |-> interrupt_priority_inputs == 3'h0)
    else $error("interrupt level during reset delay"); // RL11
  breakpoint_instr_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    breakpoint_instr |=> exc_req && exc_vector == 8'h04)
    else $error("breakpoint not illegal instruction"); // RL12
  cop_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cop_instr && !breakpoint_instr && cop_id != 3'h1
      |=> exc_req && exc_vector == 8'h0b)
    else $error("foreign coprocessor not trapped"); // RL14
  diag_lvl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    diag_irq [*3] ##0 !reset_busy |=> interrupt_priority_inputs == 3'h7)
    else $error("diagnostic not level seven"); // RL16
  free_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
    free_q <= 4'(CMD_BUFS))
    else $error("free count above buffers"); // RL24
  lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rmw_q == PMD_RMW_LOCK |-> arb_modify)
    else $error("lock released mid cycle"); // RL9
endmodule
`default_nettype wire

// ==== pmd_regs.svh ====
// register offsets, reset values and timing counts for the decode block
`ifndef PMD_REGS_SVH
`define PMD_REGS_SVH
`define PMD_OFF_CTRL 8'h00
`define PMD_OFF_STATUS 8'h04
`define PMD_OFF_IRQ 8'h08
`define PMD_OFF_FREEBUF 8'h0c
`define PMD_OFF_IOMAP_IDX 8'h10
`define PMD_OFF_IOMAP_DATA 8'h14
`define PMD_OFF_ACK_DONE 8'h18
`define PMD_OFF_LEVEL 8'hfc
`define PMD_CTRL_ROM_NORMAL 0
`define PMD_CTRL_FPU_PRESENT 1
`define PMD_CTRL_RESET 32'h0000_0002
`define PMD_CLK_MHZ 100
`define PMD_RST_DELAY_US 100
`define PMD_RST_CYCLES (`PMD_RST_DELAY_US * `PMD_CLK_MHZ)
`define PMD_MISS_WAIT 6
`define PMD_ROM_BYTES 32'h0001_0000
`define PMD_PAGE_BITS 12
`define PMD_SECTION_BITS 20
`define PMD_FPU_CPID 3'h1
`define PMD_VEC_FLINE 8'h0b
`define PMD_VEC_ILLEGAL 8'h04
`define PMD_VEC_AUTO_BASE 8'h18
`define PMD_CMD_BUFS 2
`endif

// ==== pmd_pkg.sv ====
// types shared by the decode block
package pmd_pkg;
  typedef enum logic [1:0] {
    PMD_SP_USER = 2'h0,
    PMD_SP_KERNEL = 2'h1,
    PMD_SP_IO = 2'h2,
    PMD_SP_LOCAL = 2'h3
  } pmd_space_t;
  typedef enum logic [1:0] {
    PMD_RMW_IDLE = 2'h0,
    PMD_RMW_WAIT = 2'h1,
    PMD_RMW_LOCK = 2'h3
  } pmd_rmw_t;
endpackage

// ==== pmd_arb_model.sv ====
// bus arbiter lock model facing the read-modify-write path
`timescale 1ns/10ps
`default_nettype none
module pmd_arb_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // lock handshake
  input wire logic arb_modify,
  input wire logic other_lock,
  input wire logic [3:0] grant_delay,
  output logic arb_lock_grant
);
  logic [3:0] cnt_q;
  // no grant while another port holds its lock
  always_ff @(posedge aclk) begin
    if (!aresetn || !arb_modify) begin
      cnt_q <= 4'h0;
      arb_lock_grant <= 1'b0;
    end else if (cnt_q < grant_delay) begin
      cnt_q <= cnt_q + 4'h1;
    end else begin
      arb_lock_grant <= arb_lock_grant || !other_lock;
    end
  end
endmodule
`default_nettype wire

// ==== pm_decode_and_interrupt_logic_tb.sv ====
// self-checking bench for the decode and interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "pmd_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end end
module pm_decode_and_interrupt_logic_tb;
  localparam int RSTC = 20;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, exc_vector, iack_vector;
  logic [31:0] s_axi_wdata, s_axi_rdata, cpu_addr, io_phys, rd, m;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, cpu_space, exc_frame_words_m4, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, cpu_as, cpu_super, cpu_write;
  logic cpu_rmw, cpu_hit, bus_fault, bus_err, rom_sel, user_root_sel;
  logic [19:0] page_num;
  logic [2:0] wait_cnt, cop_id, interrupt_priority_inputs;
  logic arb_modify, arb_lock_grant, foreign_write, foreign_overwritten;
  logic reset_instr, breakpoint_instr, cop_instr, cop_bad_encoding;
  logic exc_req, reset_busy, diag_irq, cmd_write, cmd_wait, iack;
  logic other_lock, x;
  logic [31:0] sp_a [4] = '{32'h0000_1000, 32'h8000_0000,
                            32'hc050_1234, 32'hff00_0000};
  int miscompares, tests_run, free_m, n, k, lvl, irq_m;

  pmd_top #(.RST_CYCLES(RSTC)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_as,
    .cpu_super, .cpu_write, .cpu_addr, .cpu_rmw, .cpu_hit, .bus_fault,
    .bus_err, .cpu_space, .rom_sel, .user_root_sel, .page_num, .io_phys,
    .wait_cnt, .arb_modify, .arb_lock_grant, .foreign_write,
    .foreign_overwritten, .reset_instr, .breakpoint_instr, .cop_instr,
    .cop_id, .cop_bad_encoding, .exc_req, .exc_vector,
    .exc_frame_words_m4, .reset_busy, .diag_irq, .cmd_write, .cmd_wait,
    .iack, .iack_vector, .interrupt_priority_inputs);
  pmd_arb_model arb_u (.aclk, .aresetn, .arb_modify, .other_lock,
    .grant_delay(4'h3), .arb_lock_grant);

  always #5 aclk = ~aclk;

  task automatic final_report();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tmo();
    miscompares++;
    $display("[FAIL] %0t bus wait expired", $time);
    final_report();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int c;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    c = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      c++;
    end while (!s_axi_bvalid && c < 50);
    rr = s_axi_bresp;
    s_axi_bready <= 0;
    if (c >= 50) tmo();
  endtask

  task automatic rd_t(input logic [7:0] a);
    int c;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    c = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      c++;
    end while (!s_axi_rvalid && c < 50);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    if (c >= 50) tmo();
  endtask

  task automatic cpu(input logic s, w, h, f, input logic [31:0] a);
    @(posedge aclk);
    {cpu_as, cpu_super, cpu_write, cpu_hit, bus_fault} <= {1'b1, s, w, h, f};
    cpu_addr <= a;
    @(posedge aclk);
    {cpu_as, bus_fault} <= 2'h0;
    @(negedge aclk);
  endtask

  task automatic pulse(input logic [4:0] sel);
    @(posedge aclk);
    {breakpoint_instr, cop_instr, iack, reset_instr, cmd_write} <= sel;
    @(posedge aclk);
    {breakpoint_instr, cop_instr, iack, reset_instr, cmd_write} <= 5'h0;
    @(negedge aclk);
  endtask

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid,
     s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cpu_as, cpu_super, cpu_write, cpu_addr, cpu_rmw, cpu_hit, bus_fault,
     foreign_write, reset_instr, breakpoint_instr, cop_instr, cop_id,
     cop_bad_encoding, diag_irq, cmd_write, iack, other_lock} = '0;
    free_m = `PMD_CMD_BUFS;
    n = $urandom(32'h9b3e);
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd_t(8'h00);
    `CHK(rd, `PMD_CTRL_RESET)
    wr(8'h18, 0);
    `CHK(rr, 2'h0)
    rd_t(8'h0c);
    `CHK(rd, 32'(free_m))
    rd_t(8'h40);
    `CHK(rr, 2'b10)
    cpu(1, 0, 1, 0, 32'h0000_1000);
    `CHK(rom_sel, 1'b1)
    wr(8'h00, 32'h3);
    m = $urandom & 32'hfff;
    wr(8'h10, 32'h5);
    wr(8'h14, m);
    for (int i = 0; i < 4; i++) begin
      cpu(1, 0, 1, 0, sp_a[i]);
      `CHK(cpu_space, 2'(i))
      `CHK(rom_sel, 1'(i == 3))
      `CHK(user_root_sel, 1'(i == 0))
      cpu(0, 0, 1, 0, sp_a[i]);
      `CHK(bus_err, 1'(i != 0))
    end
    cpu(1, 0, 1, 0, 32'hc050_1234);
    `CHK(io_phys, {m[11:0], 20'h0_1234})
    cpu(0, 0, 1, 0, 32'h7fff_f123);
    `CHK(page_num, 20'h7_ffff)
    cpu(1, 0, 1, 1, 32'h8000_0000);
    `CHK(bus_err, 1'b1)
    cpu(1, 1, 1, 0, 32'h8000_0000);
    `CHK(wait_cnt, 3'h0)
    cpu(1, 0, 0, 0, 32'h8000_0000);
    `CHK(wait_cnt, 3'(`PMD_MISS_WAIT))
    cpu(1, 0, 1, 0, 32'h8000_0000);
    `CHK(wait_cnt, 3'h0)
    @(posedge aclk);
    {cpu_as, cpu_write} <= 2'h3;
    @(posedge aclk);
    cpu_write <= 0;
    @(posedge aclk);
    cpu_as <= 0;
    @(negedge aclk);
    `CHK(wait_cnt, 3'h1)
    pulse(5'h10);
    `CHK(exc_req, 1'b1)
    `CHK(exc_vector, `PMD_VEC_ILLEGAL)
    `CHK(exc_frame_words_m4, 2'h0)
    for (int f = 1; f >= 0; f--) begin
      wr(8'h00, 32'(2 * f + 1));
      for (int c = 0; c < 16; c++) begin
        {cop_bad_encoding, cop_id} <= 4'(c);
        pulse(5'h08);
        x = !(f == 1 && c == `PMD_FPU_CPID);
        `CHK(exc_req, x)
        if (x) `CHK(exc_vector, `PMD_VEC_FLINE)
      end
    end
    repeat (4) begin
      irq_m = $urandom & 32'h7f;
      wr(8'h08, irq_m);
      lvl = 0;
      for (int b = 0; b < 7; b++) if (irq_m[b]) lvl = b + 1;
      rd_t(8'hfc);
      `CHK(interrupt_priority_inputs, 3'(lvl))
      `CHK(rd, 32'(lvl))
      pulse(5'h04);
      `CHK(iack_vector, 8'(`PMD_VEC_AUTO_BASE + lvl))
      rd_t(8'h08);
      `CHK(rd, irq_m)
    end
    wr(8'h08, 0);
    diag_irq <= 1;
    repeat (4) @(negedge aclk);
    `CHK(interrupt_priority_inputs, 3'h7)
    pulse(5'h02);
    n = 0;
    for (k = 0; k < 200 && !(n > 0 && !reset_busy); k++) begin
      if (reset_busy) n++;
      if (reset_busy && n == 2) `CHK(interrupt_priority_inputs, 3'h0)
      @(negedge aclk);
    end
    `CHK(n, RSTC)
    rd_t(8'h00);
    `CHK(rd, 32'h1)
    `CHK(interrupt_priority_inputs, 3'h7)
    diag_irq <= 0;
    repeat (2) pulse(5'h01);
    rd_t(8'h0c);
    `CHK(rd, 32'(free_m - 2))
    `CHK(interrupt_priority_inputs, 3'h7)
    @(posedge aclk);
    cmd_write <= 1;
    repeat (2) @(negedge aclk);
    `CHK(cmd_wait, 1'b1)
    wr(8'h18, 0);
    for (k = 0; k < 20 && cmd_wait; k++) @(negedge aclk);
    `CHK(cmd_wait, 1'b0)
    @(posedge aclk);
    cmd_write <= 0;
    rd_t(8'h0c);
    `CHK(rd, 32'h0)
    @(posedge aclk);
    {cpu_as, cpu_super, cpu_rmw, cpu_write, other_lock} <= 5'h1d;
    repeat (6) @(negedge aclk);
    `CHK(arb_modify, 1'b1)
    @(posedge aclk);
    other_lock <= 0;
    for (k = 0; k < 20 && !arb_lock_grant; k++) @(posedge aclk);
    foreign_write <= 1;
    @(posedge aclk);
    {foreign_write, cpu_write} <= 2'h1;
    x = 0;
    for (k = 0; k < 8 && !x; k++) begin
      @(negedge aclk);
      x = foreign_overwritten;
    end
    @(posedge aclk);
    {cpu_as, cpu_rmw} <= 2'h0;
    `CHK(x, 1'b1)
    repeat (4) @(negedge aclk);
    `CHK(arb_modify, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire
